// ==== rtl/exception_status_save_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "exc_save_map.vh"

// Operation
// (RULE1) interrupt taken with handler flag clear saves live state to exception copy
// (RULE2) shadow bank interrupt saves to shadow copy instead when banks exist
// (RULE3) exception return restores from exception or shadow copy by current bank
// (RULE4) exception copy is software read/write and resets to zero
// (RULE5) saved copies keep the live state layout, bits 23 down to 0
// (RULE6) break saves the live state into the break copy
// (RULE7) break return restores live state from the break copy
// (RULE8) break copy is software read/write and resets to zero
// (RULE9) mask has one enable bit per request input 0 to 31
// (RULE10) mask reads zero when internal interrupt controller is absent
// (RULE11) waiting bits equal request inputs AND mask
// (RULE12) writes to waiting bits are ignored
// (RULE13) waiting register exists only with internal interrupt controller
// (RULE14) core id is a build constant; writes ignored
// (RULE15) extra info built always with translation or protection, else by option
// (RULE16) fatal ECC flag: 1 register-file error, 0 other ECC; read-only
// (RULE17) cause field records highest-priority exception code
// (RULE18) cause unchanged on break or external-controller interrupt
// (RULE19) unbuilt fields read zero and behave as zero
// (RULE20) software must not set handler and user flags together
// (RULE21) handler flag set on any exception taken, including break
// (RULE22) previous bank takes current bank after saving live state
// (RULE23) restored state applies from the first fetch at the return target
module exception_status_save_regs #(
	parameter HAS_IIC = 1,
	parameter HAS_EIC = 0,
	parameter HAS_SHADOW = 0,
	parameter HAS_MMU = 0,
	parameter HAS_MPU = 0,
	parameter HAS_ECC = 0,
	parameter EXTRA_INFO_OPT = 0,
	parameter [31:0] CORE_ID = 32'h0000_0000 // arbitrary value
) (
	input wire clock,
	input wire srst,
	input wire [31:0] irq_req,
	input wire [`ST_W-1:0] live_state,
	input wire exc_taken,
	input wire exc_is_irq,
	input wire irq_wants_shadow,
	input wire irq_is_ext,
	input wire break_taken,
	input wire cause_valid,
	input wire [`CAUSE_W-1:0] cause_code,
	input wire ecc_fatal,
	input wire ecc_in_regfile,
	input wire exc_return,
	input wire break_return,
	input wire [`ST_W-1:0] shadow_saved_state,
	input wire cr_write,
	input wire [`CR_SEL_W-1:0] cr_sel,
	input wire [31:0] cr_wdata,
	output reg [31:0] cr_rdata,
	output wire save_to_shadow,
	output reg restore_valid,
	output reg [`ST_W-1:0] restore_state,
	output reg handler_flag_set,
	output wire [31:0] irq_waiting_bits,
	output wire irq_any_waiting
);
	// extra info is forced on by translation or protection
	localparam EXTRA_INFO = (HAS_MMU != 0) || (HAS_MPU != 0) || (EXTRA_INFO_OPT != 0); // RULE15
	// handler flag exists with translation or ECC
	localparam HANDLER_BUILT = (HAS_MMU != 0) || (HAS_ECC != 0);
	// user flag exists with translation or protection
	localparam USER_BUILT = (HAS_MMU != 0) || (HAS_MPU != 0);

	// per-field mask of built features
	wire [`ST_W-1:0] field_mask;
	wire [`BANK_W-1:0] bank_mask;
	wire [5:0] level_mask;
	wire [7:0] reserved_mask;
	wire bank_irq_en_mask;
	wire nmi_mask;
	wire ext_handler_mask;
	wire exc_handler_mask;
	wire user_mask;
	wire gate_mask;

	// shadow banks own the bank fields and their interrupt enable
	assign bank_mask = (HAS_SHADOW != 0) ? {`BANK_W{1'b1}} : `ZERO_BANK;
	assign bank_irq_en_mask = (HAS_SHADOW != 0) ? 1'b1 : 1'b0;

	// external controller owns level, nonmaskable and handler-mode fields
	assign level_mask = (HAS_EIC != 0) ? 6'h3f : 6'h00;
	assign nmi_mask = (HAS_EIC != 0) ? 1'b1 : 1'b0;
	assign ext_handler_mask = (HAS_EIC != 0) ? 1'b1 : 1'b0;

	// handler and user flags follow their owning features
	assign exc_handler_mask = HANDLER_BUILT ? 1'b1 : 1'b0;
	assign user_mask = USER_BUILT ? 1'b1 : 1'b0;
	assign gate_mask = 1'b1; // gate always built
	assign reserved_mask = 8'h00; // bits above 23 never hold state

	// assembled in live-state order, msb first
	assign field_mask = {reserved_mask, bank_irq_en_mask, nmi_mask, bank_mask, bank_mask, level_mask,
		ext_handler_mask, exc_handler_mask, user_mask, gate_mask}; // RULE5 RULE19

	// save-event decode
	wire handler_busy;
	wire irq_save;
	wire nonirq_save;
	wire exc_capture;
	wire break_capture;

	// a set handler flag blocks nested saves into the exception copy
	assign handler_busy = live_state[`ST_EXC_HANDLER] & field_mask[`ST_EXC_HANDLER]; // RULE19

	// interrupt path: shadow copy when asked and built, exception copy otherwise
	assign irq_save = exc_taken & exc_is_irq & ~handler_busy; // RULE1
	assign save_to_shadow = irq_save & irq_wants_shadow & (HAS_SHADOW != 0); // RULE2

	// nonbreak, noninterrupt exceptions use the exception copy too
	assign nonirq_save = exc_taken & ~exc_is_irq & ~handler_busy;
	assign exc_capture = nonirq_save | (irq_save & ~save_to_shadow); // RULE1 RULE2

	// breaks always save, whatever the handler flag says
	assign break_capture = break_taken; // RULE6

	// selector decode shared by the write strobes
	wire sel_exc;
	wire sel_brk;
	wire sel_mask;
	assign sel_exc = (cr_sel == `CR_EXC_SAVED);
	assign sel_brk = (cr_sel == `CR_BREAK_SAVED);
	assign sel_mask = (cr_sel == `CR_IRQ_MASK);

	// software write strobes, read-only selectors get none
	wire wr_exc;
	wire wr_brk;
	wire wr_mask;
	assign wr_exc = cr_write & sel_exc; // RULE4
	assign wr_brk = cr_write & sel_brk; // RULE8
	assign wr_mask = cr_write & sel_mask & (HAS_IIC != 0); // RULE10 RULE12

	wire [`ST_W-1:0] exc_saved_state;
	wire [`ST_W-1:0] break_saved_state;

	// exception-saved copy
	saved_state_reg u_exc_saved (
		.clock(clock),
		.srst(srst),
		.capture(exc_capture), // RULE22
		.live_state(live_state),
		.sw_write(wr_exc),
		.sw_data(cr_wdata),
		.field_mask(field_mask),
		.value(exc_saved_state)
	);

	// break-saved copy
	saved_state_reg u_break_saved (
		.clock(clock),
		.srst(srst),
		.capture(break_capture), // RULE22
		.live_state(live_state),
		.sw_write(wr_brk),
		.sw_data(cr_wdata),
		.field_mask(field_mask),
		.value(break_saved_state)
	);

	// interrupt enable mask, one bit per request input
	reg [31:0] irq_mask_bits_ff;
	reg [31:0] nxt_irq_mask_bits;
	always @* begin
		nxt_irq_mask_bits = irq_mask_bits_ff;
		if (wr_mask) begin
			nxt_irq_mask_bits = cr_wdata; // RULE9
		end
	end

	// mask register, cleared by reset
	always @(posedge clock) begin
		if (srst) begin
			irq_mask_bits_ff <= `ZERO32;
		end else begin
			irq_mask_bits_ff <= nxt_irq_mask_bits;
		end
	end

	// mask read value and waiting bits, both zero without the internal controller
	wire [31:0] irq_mask_bits;
	assign irq_mask_bits = (HAS_IIC != 0) ? irq_mask_bits_ff : `ZERO32; // RULE10
	assign irq_waiting_bits = (HAS_IIC != 0) ? (irq_req & irq_mask_bits) : `ZERO32; // RULE11 RULE13
	assign irq_any_waiting = |irq_waiting_bits;

	// exception info record
	reg fatal_regfile_ecc_flag_ff;
	reg [`CAUSE_W-1:0] cause_ff;
	reg nxt_fatal_regfile_ecc_flag;
	reg [`CAUSE_W-1:0] nxt_cause;
	wire ecc_write;
	wire cause_write;
	wire cause_blocked;

	// breaks and external-controller interrupts leave the cause alone
	assign cause_blocked = break_taken | (exc_is_irq & irq_is_ext); // RULE18
	assign cause_write = EXTRA_INFO & exc_taken & cause_valid & ~cause_blocked; // RULE17
	assign ecc_write = ecc_fatal & (HAS_ECC != 0); // RULE16

	// next values of the two recorded fields
	always @* begin
		nxt_fatal_regfile_ecc_flag = fatal_regfile_ecc_flag_ff;
		nxt_cause = cause_ff;
		if (ecc_write) begin
			nxt_fatal_regfile_ecc_flag = ecc_in_regfile; // RULE16
		end
		if (cause_write) begin
			nxt_cause = cause_code; // RULE17
		end
	end

	// fatal ECC flag, read-only to software
	always @(posedge clock) begin
		if (srst) begin
			fatal_regfile_ecc_flag_ff <= 1'b0;
		end else begin
			fatal_regfile_ecc_flag_ff <= nxt_fatal_regfile_ecc_flag;
		end
	end

	// cause field, read-only to software
	always @(posedge clock) begin
		if (srst) begin
			cause_ff <= `ZERO_CAUSE;
		end else begin
			cause_ff <= nxt_cause;
		end
	end

	// record layout: ECC flag on top, cause in bits 6 to 2, zeros elsewhere
	wire [23:0] info_pad_high;
	wire [1:0] info_pad_low;
	wire [31:0] exc_info_record;
	assign info_pad_high = 24'h00_0000;
	assign info_pad_low = 2'b00;
	assign exc_info_record = {fatal_regfile_ecc_flag_ff, info_pad_high, cause_ff, info_pad_low};

	// restore sources; a nonzero current bank means the state sits in the shadow copy
	wire shadow_active;
	wire [`ST_W-1:0] shadow_restore;
	wire [`ST_W-1:0] exc_restore;
	assign shadow_active = |(live_state[`ST_CUR_BANK_MSB:`ST_CUR_BANK_LSB] & bank_mask);
	assign shadow_restore = shadow_saved_state & field_mask; // RULE19
	assign exc_restore = shadow_active ? shadow_restore : exc_saved_state; // RULE3

	// restore request, break return first
	reg nxt_restore_valid;
	reg [`ST_W-1:0] nxt_restore_state;
	always @* begin
		nxt_restore_valid = 1'b0;
		nxt_restore_state = `ZERO32;
		if (break_return) begin
			nxt_restore_valid = 1'b1;
			nxt_restore_state = break_saved_state; // RULE7
		end else if (exc_return) begin
			nxt_restore_valid = 1'b1;
			nxt_restore_state = exc_restore; // RULE3
		end
	end

	// registered so restored state lands before the target fetch
	always @(posedge clock) begin
		if (srst) begin
			restore_valid <= 1'b0;
			restore_state <= `ZERO32;
		end else begin
			restore_valid <= nxt_restore_valid; // RULE23
			restore_state <= nxt_restore_state; // RULE23
		end
	end

	// handler flag request on any exception or break, only where the flag exists
	wire nxt_handler_flag_set;
	assign nxt_handler_flag_set = (exc_taken | break_taken) & HANDLER_BUILT; // RULE21

	// one-cycle pulse behind the event
	always @(posedge clock) begin
		if (srst) begin
			handler_flag_set <= 1'b0;
		end else begin
			handler_flag_set <= nxt_handler_flag_set;
		end
	end

	// read value per selector, unmapped selectors read zero
	wire [31:0] info_read_value;
	reg [31:0] nxt_cr_rdata;
	assign info_read_value = EXTRA_INFO ? exc_info_record : `ZERO32; // RULE15

	// read mux; writes to read-only selectors have no strobe
	always @* begin
		case (cr_sel)
			`CR_EXC_SAVED: nxt_cr_rdata = exc_saved_state; // RULE4
			`CR_BREAK_SAVED: nxt_cr_rdata = break_saved_state; // RULE8
			`CR_IRQ_MASK: nxt_cr_rdata = irq_mask_bits; // RULE10
			`CR_IRQ_WAITING: nxt_cr_rdata = irq_waiting_bits; // RULE12
			`CR_CORE_ID: nxt_cr_rdata = CORE_ID; // RULE14
			`CR_EXC_INFO: nxt_cr_rdata = info_read_value;
			default: nxt_cr_rdata = `ZERO32;
		endcase
	end

	// read data registered, one cycle after the selector
	always @(posedge clock) begin
		if (srst) begin
			cr_rdata <= `ZERO32;
		end else begin
			cr_rdata <= nxt_cr_rdata;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/exc_save_map.vh ====
`ifndef EXC_SAVE_MAP_VH
`define EXC_SAVE_MAP_VH

// control register selectors on the control-register access port
`define CR_SEL_W 3
`define CR_EXC_SAVED 3'h1
`define CR_BREAK_SAVED 3'h2
`define CR_IRQ_MASK 3'h3
`define CR_IRQ_WAITING 3'h4
`define CR_CORE_ID 3'h5
`define CR_EXC_INFO 3'h7

// state register layout shared by live and saved copies
`define ST_W 32
`define ST_USED_MSB 23
`define ST_BANK_IRQ_EN 23
`define ST_NMI 22
`define ST_PREV_BANK_MSB 21
`define ST_PREV_BANK_LSB 16
`define ST_CUR_BANK_MSB 15
`define ST_CUR_BANK_LSB 10
`define ST_LEVEL_MSB 9
`define ST_LEVEL_LSB 4
`define ST_EXT_HANDLER 3
`define ST_EXC_HANDLER 2
`define ST_USER 1
`define ST_GATE 0
`define BANK_W 6

// exception info record layout
`define EI_FATAL_ECC 31
`define EI_CAUSE_MSB 6
`define EI_CAUSE_LSB 2
`define CAUSE_W 5

// reset values
`define ZERO32 32'h0000_0000
`define ZERO_CAUSE 5'h00
`define ZERO_BANK 6'h00

`endif

// ==== rtl/saved_state_reg.v ====
`timescale 1ns/1ps
`default_nettype none
`include "exc_save_map.vh"

// one saved copy of the state register with field masking
module saved_state_reg (
	input wire clock,
	input wire srst,
	input wire capture,
	input wire [`ST_W-1:0] live_state,
	input wire sw_write,
	input wire [`ST_W-1:0] sw_data,
	input wire [`ST_W-1:0] field_mask,
	output wire [`ST_W-1:0] value
);
	reg [`ST_W-1:0] state_ff;
	reg [`ST_W-1:0] nxt_state;

	// capture moves current bank into previous bank on the stored copy
	always @* begin
		nxt_state = state_ff;
		if (capture) begin
			nxt_state = live_state;
			nxt_state[`ST_PREV_BANK_MSB:`ST_PREV_BANK_LSB] = live_state[`ST_CUR_BANK_MSB:`ST_CUR_BANK_LSB];
		end else if (sw_write) begin
			nxt_state = sw_data;
		end
	end

	// fields of unbuilt features stay zero
	always @(posedge clock) begin
		if (srst) begin
			state_ff <= `ZERO32;
		end else begin
			state_ff <= nxt_state & field_mask;
		end
	end

	assign value = state_ff;
endmodule
`default_nettype wire

// ==== dv/exc_save_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module exc_save_checker #(parameter HAS_MMU = 0, parameter HAS_ECC = 0, parameter [31:0] CORE_ID = 32'h0000_0000) (
	input wire clock,
	input wire srst,
	input wire [31:0] irq_req,
	input wire exc_taken,
	input wire break_taken,
	input wire exc_return,
	input wire break_return,
	input wire [2:0] cr_sel,
	input wire [31:0] cr_rdata,
	input wire restore_valid,
	input wire [31:0] restore_state,
	input wire handler_flag_set,
	input wire [31:0] irq_waiting_bits,
	input wire irq_any_waiting
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// relations between events, reads and outputs
	a_wait_subset: assert property (irq_any_waiting == |irq_waiting_bits && !(irq_waiting_bits & ~irq_req))
		else $error("bad waiting bits");
	a_exc_restore: assert property (exc_return |=> restore_valid)
		else $error("no restore");
	a_brk_restore: assert property (break_return |=> restore_valid)
		else $error("no restore");
	a_top_clear: assert property (restore_valid |-> restore_state[31:24] == 8'h00)
		else $error("bad restore");
	a_flag_raise: assert property ((HAS_MMU || HAS_ECC) && (exc_taken || break_taken) |=> handler_flag_set)
		else $error("no flag");
	a_flag_cause: assert property (handler_flag_set |-> $past(srst) || $past(exc_taken || break_taken))
		else $error("stray flag");
	a_wait_rd: assert property (!$past(srst) && $past(cr_sel)==3'h4 |-> cr_rdata==$past(irq_waiting_bits))
		else $error("bad waiting read");
	a_id_rd: assert property (!$past(srst) && $past(cr_sel) == 3'h5 |-> cr_rdata == CORE_ID)
		else $error("bad id read");
	c_exc: cover property (exc_taken);
	c_brk: cover property (break_return);
	c_flag: cover property (handler_flag_set);
endmodule
bind exception_status_save_regs exc_save_checker #(.HAS_MMU(HAS_MMU), .HAS_ECC(HAS_ECC), .CORE_ID(CORE_ID)) checker_inst (.*);
`default_nettype wire

// ==== dv/exc_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module exc_source (
	input wire logic clock,
	output logic [31:0] irq_req,
	output logic [31:0] live_state,
	output logic [4:0] cause_code,
	output wire exc_taken,
	output wire exc_is_irq,
	output wire irq_wants_shadow,
	output wire irq_is_ext,
	output wire break_taken,
	output wire cause_valid,
	output wire ecc_fatal,
	output wire ecc_in_regfile,
	output wire exc_return,
	output wire break_return
);
	logic [9:0] ev = 10'h000;
	// event strobes from one vector
	assign {break_return, exc_return, ecc_in_regfile, ecc_fatal, cause_valid, break_taken} = ev[9:4];
	assign {irq_is_ext, irq_wants_shadow, exc_is_irq, exc_taken} = ev[3:0];
	initial begin
		irq_req = 32'h8000_0001;
		live_state = 32'h0000_0000;
		cause_code = 5'h00;
	end
	// one-cycle event, state and cause kept as levels
	task automatic fire(input logic [9:0] e, input logic [31:0] st, input logic [4:0] c);
		@(negedge clock);
		ev = e;
		live_state = st[2] ? (st & 32'hffff_fffd) : st;
		cause_code = c;
		@(negedge clock);
		ev = 10'h000;
	endtask
	task automatic set_irq(input logic [31:0] v);
		@(negedge clock);
		irq_req = v;
	endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam [31:0] CORE_ID = 32'h0000_0c1d; // arbitrary value
	localparam [31:0] FM = 32'h0000_0005; // built fields: handler flag, gate
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic cr_write = 1'b0;
	logic [2:0] cr_sel = 3'h0;
	logic [31:0] cr_wdata = 32'h0000_0000;
	logic [31:0] shadow_saved_state = 32'h0000_0a50;
	logic [2:0] rst_sel [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
	wire [31:0] irq_req, live_state, cr_rdata, restore_state, irq_waiting_bits;
	wire [4:0] cause_code;
	wire exc_taken, exc_is_irq, irq_wants_shadow, irq_is_ext, break_taken, cause_valid, ecc_fatal, ecc_in_regfile;
	wire exc_return, break_return, save_to_shadow, restore_valid, handler_flag_set, irq_any_waiting;
	int bad_count = 0;
	int samples_checked = 0;
	exc_source exc_source_inst (.*);
	exception_status_save_regs #(.HAS_ECC(1), .EXTRA_INFO_OPT(1), .CORE_ID(CORE_ID)) exception_status_save_regs_inst (.*);
	initial begin
		forever #5 clock = ~clock;
	end
	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] sel, input logic [31:0] d);
		@(negedge clock);
		cr_write = 1'b1;
		cr_sel = sel;
		cr_wdata = d;
		@(negedge clock);
		cr_write = 1'b0;
	endtask
	task automatic rd(input logic [2:0] sel, input logic [31:0] exp);
		@(negedge clock);
		cr_sel = sel;
		@(negedge clock);
		chk("cr_rdata", exp, cr_rdata);
	endtask
	task automatic go(input logic [9:0] e, input logic [31:0] st, input logic [4:0] c);
		exc_source_inst.fire(e, st, c);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// reset, registers, then saves, restores and cause record
	initial begin
		repeat (3) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		foreach (rst_sel[i]) rd(rst_sel[i], 32'h0000_0000);
		for (int s = 1; s < 6; s++) wr(s[2:0], 32'hffff_ffff);
		rd(3'h1, FM);
		rd(3'h2, FM);
		rd(3'h3, 32'hffff_ffff);
		rd(3'h4, 32'h8000_0001);
		rd(3'h5, CORE_ID);
		wr(3'h3, 32'h0000_00f0);
		exc_source_inst.set_irq(32'h0000_0f3c);
		#1;
		chk("irq_waiting_bits", 32'h0000_0030, irq_waiting_bits);
		chk("irq_any_waiting", 32'h0000_0001, {31'h0, irq_any_waiting});
		go(10'h003, 32'h00ff_fffb, 5'h00);
		chk("handler_flag_set", 32'h0000_0001, {31'h0, handler_flag_set});
		rd(3'h1, 32'h0000_0001);
		go(10'h010, 32'h0000_0004, 5'h00);
		chk("handler_flag_set", 32'h0000_0001, {31'h0, handler_flag_set});
		rd(3'h2, 32'h0000_0004);
		go(10'h200, 32'h0000_0001, 5'h00);
		chk("restore_valid", 32'h0000_0001, {31'h0, restore_valid});
		chk("restore_state", 32'h0000_0004, restore_state);
		go(10'h100, 32'h0000_0001, 5'h00);
		chk("restore_state", 32'h0000_0001, restore_state);
		go(10'h021, 32'h0000_0000, 5'h0c);
		rd(3'h7, 32'h0000_0030);
		go(10'h030, 32'h0000_0000, 5'h03);
		go(10'h02b, 32'h0000_0000, 5'h03);
		rd(3'h7, 32'h0000_0030);
		go(10'h0c0, 32'h0000_0000, 5'h00);
		rd(3'h7, 32'h8000_0030);
		go(10'h040, 32'h0000_0000, 5'h00);
		rd(3'h7, 32'h0000_0030);
		go(10'h007, 32'h0000_0001, 5'h00);
		rd(3'h1, 32'h0000_0001);
		go(10'h003, 32'h0000_0004, 5'h00);
		rd(3'h1, 32'h0000_0001);
		end_of_test();
	end
endmodule
`default_nettype wire
